// ### bench/estop_checker_properties.sv
`timescale 1ns/10ps
module estop_checker #(
   parameter int STOP_QUAL_CYCLES = 20
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic stopButton,
   input wire logic resetButton,
   input wire logic emergencySafeStop,
   input wire logic moduleTorqueOff,
   input wire logic driveTorqueOff,
   input wire logic stopLamp,
   input wire logic driveFault,
   input wire logic stopRampSetZero
);
   // one domain, so clock and reset are set once
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // module torque-off always carries the drive along
   property p_mod_drv; moduleTorqueOff |-> driveTorqueOff; endproperty
   a_mod_drv: assert property (p_mod_drv) else $error("module off without drive off");
   property p_lamp_drv; stopLamp |-> driveTorqueOff; endproperty
   a_lamp_drv: assert property (p_lamp_drv) else $error("lamp while drive enabled");
   // a fault only follows a trip, which always cuts the module too
   property p_fault_trip; driveFault |-> moduleTorqueOff; endproperty
   a_fault_trip: assert property (p_fault_trip) else $error("fault without trip");
   property p_release; $fell(driveTorqueOff) |-> !stopLamp && !moduleTorqueOff && !driveFault;
   endproperty
   a_release: assert property (p_release) else $error("partial release");
   // release only after both buttons are let go
   property p_rel_btn; $fell(driveTorqueOff) |-> !stopButton && !resetButton; endproperty
   a_rel_btn: assert property (p_rel_btn) else $error("release with a button held");
   // while reset is still pressed neither drive torque-off nor the fault may drop yet
   property p_hold_off; driveTorqueOff && resetButton |=> driveTorqueOff; endproperty
   a_hold_off: assert property (p_hold_off) else $error("torque-off dropped early");
   property p_hold_fault; driveFault && resetButton |=> driveFault; endproperty
   a_hold_fault: assert property (p_hold_fault) else $error("fault dropped early");
   property p_emerg_set; $rose(stopRampSetZero) |-> $past(emergencySafeStop); endproperty
   a_emerg_set: assert property (p_emerg_set) else $error("set zero without emergency");
   // an immediate stop needs the request to have been present one full qualifying time earlier
   property p_qual;
      $rose(moduleTorqueOff) && !driveFault |-> $past(stopButton, STOP_QUAL_CYCLES);
   endproperty
   a_qual: assert property (p_qual) else $error("stop taken too soon");
endmodule
bind emergency_stop_sequencer estop_checker #(.STOP_QUAL_CYCLES(STOP_QUAL_CYCLES)) chk (
   .core_clk, .rst, .stopButton, .resetButton, .emergencySafeStop, .moduleTorqueOff,
   .driveTorqueOff, .stopLamp, .driveFault, .stopRampSetZero);

// ### bench/motor_model.sv
`timescale 1ns/10ps
module motor_model #(
   parameter int MS_CYCLES = 10
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [15:0] loadSpeed,
   input wire logic [15:0] rampRate,
   output logic [15:0] speed
);
   int tick; // cycles into the current millisecond
   // speed falls by the rate each millisecond, floored at zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         speed <= '0;
         tick <= 0;
      end else if (load) begin
         speed <= loadSpeed;
         tick <= 0;
      end else if (tick == MS_CYCLES - 1) begin
         tick <= 0;
         speed <= (speed > rampRate) ? speed - rampRate : '0;
      end else begin
         tick <= tick + 1;
      end
   end
endmodule

// ### bench/test_emergency_stop_sequencer.sv
`timescale 1ns/10ps
module test_emergency_stop_sequencer;
   import estop_pkg::*;
   logic core_clk, rst, regWr, regRd, stopButton, resetButton, emergencySafeStop, load;
   logic [AW-1:0] regAddr;
   logic [DW-1:0] regWrData, regRdData, motorSpeed, loadSpeed, rampRate;
   logic moduleTorqueOff, driveTorqueOff, stopLamp, driveFault, stopRampSetZero;
   int numErrors = 0;
   int samplesChecked = 0;
   int cycles = 0; // watchdog count
   // short counts keep the run small
   emergency_stop_sequencer #(.MS_CYCLES(10), .STOP_QUAL_CYCLES(20), .RESET_MIN_CYCLES(30),
      .RESET_MAX_CYCLES(300)) dut (.core_clk, .rst, .regAddr, .regWrData, .regWr, .regRd,
      .regRdData, .stopButton, .resetButton, .motorSpeed, .emergencySafeStop,
      .moduleTorqueOff, .driveTorqueOff, .stopLamp, .driveFault, .stopRampSetZero);
   motor_model #(.MS_CYCLES(10)) motor (.core_clk, .rst, .load, .loadSpeed, .rampRate,
      .speed(motorSpeed));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         $display("unexpected at %0t: timeout", $time);
         numErrors++;
         stop_test();
      end
   end
   task automatic clk(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chkReg(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         numErrors++;
         $display("unexpected at %0t: value %h not %h", $time, got, exp);
      end
   endtask
   // order: module off, drive off, lamp, fault
   task automatic chkOut(input logic [3:0] exp);
      // look just after the edge, once the flops have settled
      #1;
      samplesChecked++;
      if ({moduleTorqueOff, driveTorqueOff, stopLamp, driveFault} !== exp) begin
         numErrors++;
         $display("unexpected at %0t: outputs not %h", $time, exp);
      end
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 chkReg(regRdData, exp);
   endtask
   // press held well inside the accepted window
   task automatic ack();
      clk(60);
      resetButton <= 1'b1;
      clk(40);
      resetButton <= 1'b0;
      clk(5);
      chkOut(4'h0);
   endtask
   // motor starts at 300, stop or emergency held 30 cycles, two checkpoints
   task automatic run(input logic [2:0] ctrl, input logic [DW-1:0] rate, input bit emerg,
      input int w1, input logic [3:0] e1, input int w2, input logic [3:0] e2);
      wr(OFS_CTRL, {13'h0000, ctrl});
      @(posedge core_clk);
      rampRate <= rate;
      loadSpeed <= 16'h012C;
      load <= 1'b1;
      if (emerg) emergencySafeStop <= 1'b1;
      else stopButton <= 1'b1;
      clk(1);
      load <= 1'b0;
      clk(29);
      stopButton <= 1'b0;
      emergencySafeStop <= 1'b0;
      clk(w1);
      chkOut(e1);
      if (emerg) chkReg({15'h0000, stopRampSetZero}, 16'h0001);
      clk(w2);
      chkOut(e2);
      ack();
      $display("test ctrl %h rate %0d emergency %0d done", ctrl, rate, emerg);
   endtask
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", numErrors, samplesChecked);
      if (numErrors == 0 && samplesChecked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      {regWr, regRd, stopButton, resetButton, emergencySafeStop, load} = '0;
      regAddr = '0;
      regWrData = '0;
      loadSpeed = '0;
      rampRate = '0;
      rst = 1'b1;
      clk(10);
      rst <= 1'b0;
      rd(OFS_CTRL, 16'h0000);
      rd(OFS_ZLIM_EST, ZLIM_RST);
      rd(OFS_COAST, TIME_RST);
      rd(OFS_EXTRA, EXTRA_RST);
      rd(OFS_RAMP_B, MARGIN_RST);
      rd(8'h30, 16'h0000);
      rd(OFS_STATUS, 16'h0000);
      wr(OFS_COAST, 16'h0005);
      wr(OFS_RESTART, 16'h0002);
      wr(OFS_MONITOR, 16'h000F);
      wr(OFS_EXTRA, 16'h0002);
      wr(OFS_RAMP_A, 16'h000A);
      rd(OFS_MONITOR, 16'h000F);
      $display("test register defaults done");
      run(3'h0, 16'h0000, 0, 10, 4'hC, 50, 4'hE);
      run(3'h1, 16'h001E, 0, 40, 4'h0, 160, 4'h6);
      run(3'h1, 16'h0000, 0, 170, 4'hD, 60, 4'hF);
      run(3'h3, 16'h001E, 0, 40, 4'h0, 160, 4'h6);
      run(3'h3, 16'h0000, 0, 70, 4'h0, 60, 4'hD);
      run(3'h4, 16'h000F, 0, 60, 4'hC, 110, 4'hE);
      run(3'h0, 16'h001E, 1, 40, 4'h0, 160, 4'h6);
      // long coast: acknowledge must still work once the restart delay is over
      wr(OFS_COAST, 16'h0014);
      stopButton <= 1'b1;
      clk(30);
      stopButton <= 1'b0;
      wr(OFS_CTRL, 16'h0001);
      rd(OFS_CTRL, 16'h0000);
      resetButton <= 1'b1;
      clk(10);
      resetButton <= 1'b0;
      clk(5);
      chkOut(4'hC);
      ack();
      $display("test flying restart done");
      stop_test();
   end
endmodule

// ### verilog/emergency_stop_sequencer.sv
// Notes on behaviour
// - cat0 no encoder: torque-off, start both timers
// - restart delay over permits acknowledge
// - cat0 no encoder: coast expiry lights lamp
// - acknowledge releases torque-off, lamp off
// - cat1 time: stop starts monitor timer
// - below zero limit: drive torque-off, lamp
// - optional extra delay before torque-off
// - monitor expiry ignored once torque-off
// - monitor expiry above limit: trip, coast
// - after trip, lamp and acknowledge at coast
// - trip raises fault to the drive
// - cat1 ramp: stop starts ramp supervision
// - ramp zero reached: torque-off, stop, lamp
// - outside ramp window: trip, coast counter
// - after ramp trip, acknowledge at coast
// - cat0 encoder: restart timer only
// - cat0 encoder: lamp below encoder limit
// - reset accepted within window, stop released
// - emergency stop overrides, uses set zero
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module emergency_stop_sequencer #(
   parameter int MS_CYCLES = estop_pkg::MS_CYC,
   parameter int STOP_QUAL_CYCLES = estop_pkg::STOP_QUAL_CYC,
   parameter int RESET_MIN_CYCLES = estop_pkg::RESET_MIN_CYC,
   parameter int RESET_MAX_CYCLES = estop_pkg::RESET_MAX_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   // register port
   input wire logic [estop_pkg::AW-1:0] regAddr,
   input wire logic [estop_pkg::DW-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [estop_pkg::DW-1:0] regRdData,
   // buttons, asynchronous pins
   input wire logic stopButton,
   input wire logic resetButton,
   // speed from estimator or encoder, same clock
   input wire logic [estop_pkg::DW-1:0] motorSpeed,
   // internal emergency safe-stop request
   input wire logic emergencySafeStop,
   // outputs
   output logic moduleTorqueOff,
   output logic driveTorqueOff,
   output logic stopLamp,
   output logic driveFault,
   output logic stopRampSetZero
);
   import estop_pkg::*;

   // long counter limits at counter width, ms prescaler limit at data width
   localparam logic [CW-1:0] QUAL_LIM = CW'(STOP_QUAL_CYCLES);
   localparam logic [CW-1:0] RMIN_LIM = CW'(RESET_MIN_CYCLES);
   localparam logic [CW-1:0] RMAX_LIM = CW'(RESET_MAX_CYCLES);
   localparam logic [DW-1:0] MS_LAST = DW'(MS_CYCLES - 1);

   // whole module state
   typedef struct packed {
      logic s1Stop;            // synchroniser stage one
      logic s2Stop;            // synchroniser stage two
      logic s1Rst;
      logic s2Rst;
      logic [CW-1:0] qualCnt;  // stop hold time
      logic [CW-1:0] rstCnt;   // reset hold time
      logic [DW-1:0] msCnt;    // millisecond prescaler
      logic [DW-1:0] seqMs;    // ms since stop
      logic [DW-1:0] phaseMs;  // ms since zero, trip or cat0 stop
      logic [DW-1:0] startSpeed;
      seq_state_t st;
      logic tripped;           // monitoring limit hit
      logic emergRamp;         // emergency ramp set in use
      logic ackOk;             // acknowledge permitted
      logic lamp;
      logic modTo;
      logic drvTo;
      logic fault;
      logic [DW-1:0] rdData;
      logic [2:0] ctrl;        // category, ramp, encoder
      logic [DW-1:0] zEst;
      logic [DW-1:0] zEnc;
      logic [DW-1:0] coastT;
      logic [DW-1:0] restartT;
      logic [DW-1:0] monT;
      logic [DW-1:0] extraT;
      logic [DW-1:0] rampRate; // set one, per ms
      logic [DW-1:0] rampMargin;
      logic [DW-1:0] emergRate; // set zero, per ms
   } state_t;

   state_t s;
   state_t next_s;

   // saturating millisecond increment
   function automatic logic [DW-1:0] satInc(input logic [DW-1:0] v);
      satInc = (v == {DW{1'b1}}) ? v : v + 16'h0001;
   endfunction

   // ceiling of the ramp window after ms elapsed
   function automatic logic [32:0] rampCeil(
      input logic [DW-1:0] start,
      input logic [DW-1:0] margin,
      input logic [DW-1:0] rate,
      input logic [DW-1:0] ms
   );
      logic [32:0] top;
      logic [32:0] drop;
      // 33 bits so start plus margin never wraps
      top = {17'h0_0000, start} + {17'h0_0000, margin};
      // full-width product; a 16-bit one would wrap on long ramps
      drop = {17'h0_0000, rate} * {17'h0_0000, ms};
      rampCeil = (drop >= top) ? 33'h0_0000_0000 : top - drop;
   endfunction

   // decoded views of the state
   logic stopValid;
   logic msTick;
   logic enc;
   logic cat1;
   logic rampMode;
   logic [DW-1:0] zLim;
   logic belowZero;
   logic coastDone;
   logic rampOut;
   logic [DW-1:0] rate;

   // combinational next state
   always_comb begin
      next_s = s;
      // two-flop synchronisers for the buttons
      // pins are asynchronous; only the second stage is read
      next_s.s1Stop = stopButton;
      next_s.s2Stop = s.s1Stop;
      next_s.s1Rst = resetButton;
      next_s.s2Rst = s.s1Rst;

      enc = s.ctrl[CTRL_ENC];
      cat1 = s.ctrl[CTRL_CAT1];
      rampMode = s.ctrl[CTRL_RAMP];
      zLim = enc ? s.zEnc : s.zEst;
      belowZero = motorSpeed < zLim;
      // coasting finished: timer, or measured speed
      coastDone = enc ? (motorSpeed < s.zEnc) : (s.phaseMs >= s.coastT);
      // emergency set replaces the normal ramp
      rate = s.emergRamp ? s.emergRate : s.rampRate;
      // ramp window: speed above the falling ceiling is a trip
      rampOut = {17'h0_0000, motorSpeed} >
         rampCeil(s.startSpeed, s.rampMargin, rate, s.seqMs);

      // stop counts only after a steady hold
      // a short bounce never reaches the limit and is dropped
      if (!s.s2Stop) begin
         next_s.qualCnt = '0;
      end else if (s.qualCnt != QUAL_LIM) begin
         next_s.qualCnt = s.qualCnt + 28'h000_0001;
      end
      stopValid = (s.qualCnt == QUAL_LIM);

      // millisecond tick for all user timers
      // user timers count whole milliseconds, so a setting is
      // accurate to one millisecond at worst
      msTick = (s.msCnt == MS_LAST);
      next_s.msCnt = msTick ? '0 : s.msCnt + 16'h0001;
      if (msTick) begin
         next_s.seqMs = satInc(s.seqMs);
         next_s.phaseMs = satInc(s.phaseMs);
      end

      // reset press length, saturates past the window
      // counting past the maximum marks a press that was too long
      if (s.s2Rst) begin
         if (s.rstCnt <= RMAX_LIM) begin
            next_s.rstCnt = s.rstCnt + 28'h000_0001;
         end
      end else begin
         next_s.rstCnt = '0;
      end

      // configuration writes only while idle
      // refusing writes outside idle keeps a running stop on the
      // settings it started with
      if (regWr && s.st == ST_IDLE) begin
         case (regAddr)
            OFS_CTRL: next_s.ctrl = regWrData[2:0];
            OFS_ZLIM_EST: next_s.zEst = regWrData;
            OFS_ZLIM_ENC: next_s.zEnc = regWrData;
            OFS_COAST: next_s.coastT = regWrData;
            OFS_RESTART: next_s.restartT = regWrData;
            OFS_MONITOR: next_s.monT = regWrData;
            OFS_EXTRA: next_s.extraT = regWrData;
            OFS_RAMP_A: next_s.rampRate = regWrData;
            OFS_RAMP_B: next_s.rampMargin = regWrData;
            OFS_RAMP_C: next_s.emergRate = regWrData;
            // unmapped or read-only: ignored
            default: next_s.ctrl = s.ctrl;
         endcase
      end

      // read data stands only in the cycle after the strobe
      next_s.rdData = '0;
      if (regRd) begin
         case (regAddr)
            OFS_CTRL: next_s.rdData = {13'h0000, s.ctrl};
            OFS_ZLIM_EST: next_s.rdData = s.zEst;
            OFS_ZLIM_ENC: next_s.rdData = s.zEnc;
            OFS_COAST: next_s.rdData = s.coastT;
            OFS_RESTART: next_s.rdData = s.restartT;
            OFS_MONITOR: next_s.rdData = s.monT;
            OFS_EXTRA: next_s.rdData = s.extraT;
            OFS_RAMP_A: next_s.rdData = s.rampRate;
            OFS_RAMP_B: next_s.rdData = s.rampMargin;
            OFS_RAMP_C: next_s.rdData = s.emergRate;
            OFS_STATUS: next_s.rdData = {6'h00, s.st, s.ackOk, s.lamp,
               s.tripped, s.emergRamp, s.fault, s.drvTo, s.modTo, s.s2Stop};
            // unmapped reads as zero
            default: next_s.rdData = '0;
         endcase
      end

      // stop sequencer
      case (s.st)
         ST_IDLE: begin
            // timers held at zero until a stop begins
            next_s.msCnt = '0;
            next_s.seqMs = '0;
            next_s.phaseMs = '0;
            // start speed captured each idle cycle for the ramp window
            next_s.startSpeed = motorSpeed;
            if (stopValid || emergencySafeStop) begin
               next_s.emergRamp = emergencySafeStop;
               if (cat1 || emergencySafeStop) begin
                  // monitor timer or ramp window runs on seqMs
                  next_s.st = ST_DECEL;
               end else begin
                  // category 0: torque off at once; coast and
                  // restart timers both start from zero here
                  next_s.st = ST_OFF;
                  next_s.modTo = 1'b1;
                  next_s.drvTo = 1'b1;
               end
            end
         end
         ST_DECEL: begin
            // drive is braking along its ramp
            if (emergencySafeStop) begin
               next_s.emergRamp = 1'b1;
            end
            // zero speed is checked first, so reaching it in the same
            // cycle as the monitor limit counts as a clean stop
            if (belowZero) begin
               // speed reached zero limit inside the limits
               next_s.st = ST_ZDELAY;
               next_s.msCnt = '0;
               next_s.phaseMs = '0;
            end else if ((!rampMode && s.seqMs >= s.monT) ||
                  (rampMode && rampOut)) begin
               // limit hit: coast out with a drive fault
               next_s.st = ST_OFF;
               next_s.modTo = 1'b1;
               next_s.drvTo = 1'b1;
               next_s.tripped = 1'b1;
               next_s.fault = 1'b1;
               next_s.msCnt = '0;
               next_s.phaseMs = '0;
            end
         end
         ST_ZDELAY: begin
            // optional hold before torque-off; monitor is
            // no longer consulted, speed already at zero
            if (s.phaseMs >= s.extraT) begin
               next_s.st = ST_OFF;
               next_s.drvTo = 1'b1;
               next_s.lamp = 1'b1;
            end
         end
         ST_OFF: begin
            // torque is off; decide lamp and acknowledge
            if (s.tripped) begin
               next_s.ackOk = coastDone;
               next_s.lamp = s.lamp | coastDone;
            end else if (cat1) begin
               next_s.ackOk = 1'b1;
            end else begin
               // category 0: restart delay allows fly-start
               next_s.ackOk = s.seqMs >= s.restartT;
               next_s.lamp = s.lamp | coastDone;
            end
            // accept on release of a press inside the window
            // stop must be released first; a held press never releases
            if (!s.s2Rst && s.rstCnt >= RMIN_LIM &&
                  s.rstCnt <= RMAX_LIM && !s.s2Stop && s.ackOk) begin
               next_s.st = ST_IDLE;
               next_s.modTo = 1'b0;
               next_s.drvTo = 1'b0;
               next_s.lamp = 1'b0;
               next_s.fault = 1'b0;
               next_s.tripped = 1'b0;
               next_s.emergRamp = 1'b0;
               next_s.ackOk = 1'b0;
            end
         end
         // unreachable code points fall back to safe stop
         default: begin
            next_s.st = ST_OFF;
            next_s.modTo = 1'b1;
            next_s.drvTo = 1'b1;
         end
      endcase
   end

   // state register
   // asynchronous reset so the state is known before the clock runs
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.st <= ST_IDLE;
         s.ctrl <= CTRL_RST;
         s.zEst <= ZLIM_RST;
         s.zEnc <= ZLIM_RST;
         s.coastT <= TIME_RST;
         s.restartT <= TIME_RST;
         s.monT <= TIME_RST;
         s.extraT <= EXTRA_RST;
         s.rampRate <= RATE_RST;
         s.rampMargin <= MARGIN_RST;
         s.emergRate <= RATE_RST;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from state flops
   // no logic after the flops, so no glitch reaches a pin
   assign regRdData = s.rdData;
   assign moduleTorqueOff = s.modTo;
   assign driveTorqueOff = s.drvTo;
   assign stopLamp = s.lamp;
   assign driveFault = s.fault;
   assign stopRampSetZero = s.emergRamp;
endmodule

// ### verilog/estop_pkg.sv
package estop_pkg;
   // core clock rate, kHz
   localparam int CLK_KHZ = 50_000;
   // cycles in one millisecond
   localparam int MS_CYC = CLK_KHZ;
   // least hold of the stop request
   localparam int STOP_QUAL_MS = 20;
   localparam int STOP_QUAL_CYC = STOP_QUAL_MS * MS_CYC;
   // reset press window, ms
   localparam int RESET_MIN_MS = 300;
   localparam int RESET_MAX_MS = 3000;
   localparam int RESET_MIN_CYC = RESET_MIN_MS * MS_CYC;
   localparam int RESET_MAX_CYC = RESET_MAX_MS * MS_CYC;
   // widths: address, data, speed, long counters
   localparam int AW = 8;
   localparam int DW = 16;
   localparam int CW = 28;
   // register byte offsets
   localparam logic [AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [AW-1:0] OFS_ZLIM_EST = 8'h04;
   localparam logic [AW-1:0] OFS_ZLIM_ENC = 8'h08;
   localparam logic [AW-1:0] OFS_COAST = 8'h0C;
   localparam logic [AW-1:0] OFS_RESTART = 8'h10;
   localparam logic [AW-1:0] OFS_MONITOR = 8'h14;
   localparam logic [AW-1:0] OFS_EXTRA = 8'h18;
   localparam logic [AW-1:0] OFS_RAMP_A = 8'h1C;
   localparam logic [AW-1:0] OFS_RAMP_B = 8'h20;
   localparam logic [AW-1:0] OFS_RAMP_C = 8'h24;
   localparam logic [AW-1:0] OFS_STATUS = 8'h28;
   // control field positions
   localparam int CTRL_CAT1 = 0;
   localparam int CTRL_RAMP = 1;
   localparam int CTRL_ENC = 2;
   // reset values
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [DW-1:0] ZLIM_RST = 16'h0032;
   localparam logic [DW-1:0] TIME_RST = 16'h03E8;
   localparam logic [DW-1:0] EXTRA_RST = 16'h0000;
   localparam logic [DW-1:0] RATE_RST = 16'h0001;
   localparam logic [DW-1:0] MARGIN_RST = 16'h0064;
   // sequencer states, gray along the path
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_DECEL = 2'h1,
      ST_ZDELAY = 2'h3,
      ST_OFF = 2'h2
   } seq_state_t;
endpackage
